// ==== pkg/nibble_alu_pkg.sv ====
// package for the nibble execution unit: opcodes, register map, request carrier
// assumes a single 100 MHz core clock and one instruction accepted per cycle
`default_nettype none
package nibble_alu_pkg;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int NIB_W = 4;
	localparam int BANK_PTR_W = 2;
	localparam int STACK_DEPTH = 3;
	localparam logic [3:0] NIB_ONE = 4'h1;
	localparam logic [3:0] NIB_ALL = 4'hf;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic RST_FLAG = 1'b1;
	localparam logic [3:0] RST_NIB = 4'h0;
	localparam logic [1:0] RST_BANK_PTR = 2'h0;

	// ----------------------------------------------------------------
	// register port map (word index, 3 bits)
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_WORD_PTR = 3'h1;
	localparam logic [2:0] REG_BANK_PTR = 3'h2;
	localparam logic [2:0] REG_FLAG = 3'h3;
	localparam logic [2:0] REG_ACTIVE_BANK = 3'h4;
	localparam logic [2:0] REG_BANK_BUF = 3'h5;
	localparam logic [2:0] REG_STACK_LEVEL = 3'h6;

	// ----------------------------------------------------------------
	// operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP                    = 5'h00,
		OP_CALL                   = 5'h01,
		OP_SUBROUTINE_RETURN      = 5'h02,
		OP_LOAD_BANK_BUFFER_IMM   = 5'h03,
		OP_ADD_MEMORY             = 5'h04,
		OP_SUBTRACT_FROM_MEMORY   = 5'h05,
		OP_INCREMENT_MEMORY       = 5'h06,
		OP_DECREMENT_MEMORY       = 5'h07,
		OP_INCREMENT_ACC          = 5'h08,
		OP_INCREMENT_WORD_POINTER = 5'h09,
		OP_DECREMENT_ACC          = 5'h0a,
		OP_DECREMENT_WORD_POINTER = 5'h0b,
		OP_XOR_MEMORY             = 5'h0c,
		OP_TWOS_COMPLEMENT_ACC    = 5'h0d,
		OP_ACC_LE_MEMORY          = 5'h0e,
		OP_ACC_LE_IMMEDIATE       = 5'h0f,
		OP_MEMORY_NONZERO_TEST    = 5'h10
	} op_t;

	typedef struct packed {
		logic valid;
		op_t op;
		logic [3:0] imm;
	} exec_req_t;

endpackage

`default_nettype wire

// ==== hdl/nibble_alu_call_stack.sv ====
// execution unit of a 4-bit core: conditional call/return with bank stack and nibble alu
// assumes ram read data is combinational from ram_addr, and the sequencer supplies pc+1
//
// Summary of operation
// - flag 1: call loads target, active bank takes buffer, push return pc and bank
// - flag 0: call falls through to next address and sets flag to 1
// - call page comes from bank buffer; equal to active bank means short call
// - return loads pc from stack top, pops up, bottom kept, flag set
// - return copies top bank level to active bank and buffer, pops together
// - load bank buffer immediate writes 4-bit page operand into bank buffer
// - add memory: acc gets ram plus acc mod 16, flag is carry
// - subtract from memory: acc gets ram minus acc, flag is no borrow
// - increment memory: acc gets ram plus one, flag is carry
// - decrement memory: acc gets ram plus Fh, flag set when ram nonzero
// - increment acc: carry never reaches the flag
// - increment word pointer: flag set when pointer was 15
// - decrement acc via Fh: flag set when acc was nonzero
// - decrement word pointer via Fh: flag set when pointer was nonzero
// - xor memory: acc gets acc xor ram word
// - twos complement acc: acc gets inverted plus one, flag set when zero
// - acc le memory: flag is acc at most ram, nothing written
// - acc le immediate: flag is acc at most operand, acc kept
// - memory nonzero test: flag set when ram word nonzero
// - ram operand addressed jointly by bank pointer and word pointer
`timescale 1ns/1ps
`default_nettype none

module nibble_alu_call_stack
	import nibble_alu_pkg::*;
#(
	parameter int PC_W = 10
) (
	input wire logic core_clk, // 100 MHz core clock
	input wire logic arst_n, // async reset, active low
	input wire exec_req_t req, // instruction issued this cycle
	input wire logic [PC_W-1:0] call_target, // operand address of a call
	input wire logic [PC_W-1:0] next_pc, // next sequence address from sequencer
	input wire logic [3:0] ram_rdata, // word at ram_addr, same cycle
	output logic [5:0] ram_addr, // bank pointer and word pointer
	output logic pc_load, // pc_value valid, one cycle
	output logic [PC_W-1:0] pc_value, // new program counter
	output logic long_call, // last taken call left the page
	output logic [3:0] active_rom_bank, // active rom bank
	output logic [3:0] rom_bank_buffer, // bank buffer
	output logic condition_flag, // condition flag
	output logic [3:0] acc, // accumulator
	input wire logic [2:0] reg_addr, // register index
	input wire logic [3:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [3:0] reg_rdata // read data, cycle after reg_rd
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (PC_W < 1 || PC_W > 16) begin : g_bad_pc_w
		$error("PC_W must be 1 to 16");
	end

	// level_ff is two bits and ram_addr six, so these sizes are fixed here
	if (STACK_DEPTH < 1 || STACK_DEPTH > 3) begin : g_bad_depth
		$error("STACK_DEPTH must be 1 to 3");
	end
	if (BANK_PTR_W != 2) begin : g_bad_bank_ptr_w
		$error("BANK_PTR_W must be 2");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [3:0] acc_ff, nxt_acc;
	logic [3:0] word_ptr_ff, nxt_word_ptr;
	logic [1:0] bank_ptr_ff;
	logic flag_ff, nxt_flag;
	logic [3:0] active_bank_ff, nxt_active_bank;
	logic [3:0] bank_buf_ff, nxt_bank_buf;
	logic [PC_W-1:0] ret_pc_ff [STACK_DEPTH];
	logic [3:0] ret_bank_ff [STACK_DEPTH];
	logic [1:0] level_ff;
	logic pc_load_ff;
	logic [PC_W-1:0] pc_value_ff;
	logic long_call_ff;
	logic [3:0] rdata_ff;
	logic acc_upd, wp_upd, do_push, do_pop;

	// ----------------------------------------------------------------
	// arithmetic
	// ----------------------------------------------------------------
	// one 5-bit adder per operand pair; bit 4 is the carry into the flag
	logic [4:0] sum_add, sum_sub, sum_inc_m, sum_dec_m, sum_dec_a, sum_neg, sum_le_i;
	logic call_taken, is_call, is_ret;

	assign sum_add = {1'b0, ram_rdata} + {1'b0, acc_ff};
	assign sum_sub = {1'b0, ram_rdata} + {1'b0, ~acc_ff} + 5'h01;
	assign sum_inc_m = {1'b0, ram_rdata} + {1'b0, NIB_ONE};
	assign sum_dec_m = {1'b0, ram_rdata} + {1'b0, NIB_ALL};
	assign sum_dec_a = {1'b0, acc_ff} + {1'b0, NIB_ALL};
	assign sum_neg = {1'b0, ~acc_ff} + {1'b0, NIB_ONE};
	// carry out is set exactly when acc is at most the operand
	assign sum_le_i = {1'b0, req.imm} + {1'b0, ~acc_ff} + 5'h01;

	// undefined opcodes decode to neither, so the stacks stay untouched
	assign is_call = req.valid && req.op == OP_CALL;
	assign is_ret = req.valid && req.op == OP_SUBROUTINE_RETURN;
	assign call_taken = is_call && flag_ff;
	assign do_push = call_taken;
	assign do_pop = is_ret;

	// ----------------------------------------------------------------
	// next-state decode
	// ----------------------------------------------------------------
	always_comb begin
		nxt_acc = acc_ff;
		nxt_word_ptr = word_ptr_ff;
		nxt_flag = flag_ff;
		nxt_active_bank = active_bank_ff;
		nxt_bank_buf = bank_buf_ff;
		acc_upd = 1'b0;
		wp_upd = 1'b0;
		if (req.valid) begin
			unique case (req.op)
				// nop and the set-status group force the flag high
				OP_NOP: begin
					nxt_flag = 1'b1;
				end
				OP_CALL: begin
					if (flag_ff) begin
						nxt_active_bank = bank_buf_ff;
					end else begin
						nxt_flag = 1'b1;
					end
				end
				OP_SUBROUTINE_RETURN: begin
					nxt_active_bank = ret_bank_ff[0];
					nxt_bank_buf = ret_bank_ff[0];
					nxt_flag = 1'b1;
				end
				OP_LOAD_BANK_BUFFER_IMM: begin
					nxt_bank_buf = req.imm;
					nxt_flag = 1'b1;
				end
				OP_ADD_MEMORY: begin
					nxt_acc = sum_add[3:0];
					nxt_flag = sum_add[4];
					acc_upd = 1'b1;
				end
				OP_SUBTRACT_FROM_MEMORY: begin
					nxt_acc = sum_sub[3:0];
					nxt_flag = sum_sub[4];
					acc_upd = 1'b1;
				end
				OP_INCREMENT_MEMORY: begin
					nxt_acc = sum_inc_m[3:0];
					nxt_flag = sum_inc_m[4];
					acc_upd = 1'b1;
				end
				OP_DECREMENT_MEMORY: begin
					nxt_acc = sum_dec_m[3:0];
					nxt_flag = sum_dec_m[4];
					acc_upd = 1'b1;
				end
				OP_INCREMENT_ACC: begin
					// carry is dropped on purpose
					nxt_acc = acc_ff + NIB_ONE;
					nxt_flag = 1'b1;
					acc_upd = 1'b1;
				end
				OP_INCREMENT_WORD_POINTER: begin
					nxt_word_ptr = word_ptr_ff + NIB_ONE;
					nxt_flag = (word_ptr_ff == NIB_ALL);
					wp_upd = 1'b1;
				end
				OP_DECREMENT_ACC: begin
					nxt_acc = sum_dec_a[3:0];
					nxt_flag = sum_dec_a[4];
					acc_upd = 1'b1;
				end
				OP_DECREMENT_WORD_POINTER: begin
					nxt_word_ptr = word_ptr_ff + NIB_ALL;
					nxt_flag = (word_ptr_ff != NIB_ZERO);
					wp_upd = 1'b1;
				end
				OP_XOR_MEMORY: begin
					nxt_acc = acc_ff ^ ram_rdata;
					nxt_flag = 1'b1;
					acc_upd = 1'b1;
				end
				OP_TWOS_COMPLEMENT_ACC: begin
					nxt_acc = sum_neg[3:0];
					nxt_flag = sum_neg[4];
					acc_upd = 1'b1;
				end
				OP_ACC_LE_MEMORY: begin
					nxt_flag = (acc_ff <= ram_rdata);
				end
				OP_ACC_LE_IMMEDIATE: begin
					nxt_flag = sum_le_i[4];
				end
				OP_MEMORY_NONZERO_TEST: begin
					nxt_flag = (ram_rdata != NIB_ZERO);
				end
				default: begin
					// undefined opcode: leave state alone
					nxt_flag = flag_ff;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// accumulator, pointers and flag
	// ----------------------------------------------------------------
	// an instruction update wins over a register write in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_ff <= RST_NIB;
		end else if (acc_upd) begin
			acc_ff <= nxt_acc;
		end else if (reg_wr && reg_addr == REG_ACC) begin
			acc_ff <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			word_ptr_ff <= RST_NIB;
		end else if (wp_upd) begin
			// wraps modulo 16 both ways; never carries into the bank pointer
			word_ptr_ff <= nxt_word_ptr;
		end else if (reg_wr && reg_addr == REG_WORD_PTR) begin
			word_ptr_ff <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bank_ptr_ff <= RST_BANK_PTR;
		end else if (reg_wr && reg_addr == REG_BANK_PTR) begin
			bank_ptr_ff <= reg_wdata[BANK_PTR_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_ff <= RST_FLAG;
		end else if (req.valid) begin
			// a software write to the flag only lands in a cycle without an instruction
			flag_ff <= nxt_flag;
		end else if (reg_wr && reg_addr == REG_FLAG) begin
			flag_ff <= reg_wdata[0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			active_bank_ff <= RST_NIB;
			bank_buf_ff <= RST_NIB;
		end else begin
			active_bank_ff <= nxt_active_bank;
			bank_buf_ff <= nxt_bank_buf;
		end
	end

	// ----------------------------------------------------------------
	// return and bank stacks
	// ----------------------------------------------------------------
	// a push on a full stack shifts the bottom entry out and loses it
	// a pop leaves the bottom level as it was, so it can be returned to twice
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				ret_pc_ff[i] <= '0;
				ret_bank_ff[i] <= RST_NIB;
			end
		end else if (do_push) begin
			ret_pc_ff[0] <= next_pc;
			ret_bank_ff[0] <= active_bank_ff;
			for (int i = 1; i < STACK_DEPTH; i++) begin
				ret_pc_ff[i] <= ret_pc_ff[i-1];
				ret_bank_ff[i] <= ret_bank_ff[i-1];
			end
		end else if (do_pop) begin
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				ret_pc_ff[i] <= ret_pc_ff[i+1];
				ret_bank_ff[i] <= ret_bank_ff[i+1];
			end
		end
	end

	// occupancy is for software visibility only; it saturates at full
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_ff <= 2'h0;
		end else if (do_push && level_ff != 2'(STACK_DEPTH)) begin
			level_ff <= level_ff + 2'h1;
		end else if (do_pop && level_ff != 2'h0) begin
			level_ff <= level_ff - 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// program counter hand-off
	// ----------------------------------------------------------------
	// refused opcodes leave pc_value alone; only pc_load tells the sequencer to jump
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= is_call || is_ret;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_value_ff <= '0;
		end else if (call_taken) begin
			pc_value_ff <= call_target;
		end else if (is_call) begin
			pc_value_ff <= next_pc;
		end else if (is_ret) begin
			pc_value_ff <= ret_pc_ff[0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			long_call_ff <= 1'b0;
		end else if (call_taken) begin
			// both banks still hold their old values, before the active bank takes the buffer
			long_call_ff <= (bank_buf_ff != active_bank_ff);
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	// zero outside the read cycle, so a stale word is never taken for an answer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= RST_NIB;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_ACC: rdata_ff <= acc_ff;
				REG_WORD_PTR: rdata_ff <= word_ptr_ff;
				REG_BANK_PTR: rdata_ff <= {2'h0, bank_ptr_ff};
				REG_FLAG: rdata_ff <= {3'h0, flag_ff};
				REG_ACTIVE_BANK: rdata_ff <= active_bank_ff;
				REG_BANK_BUF: rdata_ff <= bank_buf_ff;
				REG_STACK_LEVEL: rdata_ff <= {2'h0, level_ff};
				default: rdata_ff <= RST_NIB;
			endcase
		end else begin
			rdata_ff <= RST_NIB;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// the ram sees a pointer update one cycle later, in time for the next instruction
	assign ram_addr = {bank_ptr_ff, word_ptr_ff};
	assign pc_load = pc_load_ff;
	assign pc_value = pc_value_ff;
	assign long_call = long_call_ff;
	assign active_rom_bank = active_bank_ff;
	assign rom_bank_buffer = bank_buf_ff;
	assign condition_flag = flag_ff;
	assign acc = acc_ff;
	assign reg_rdata = rdata_ff;

endmodule

`default_nettype wire

// ==== tb/nibble_ram_model.sv ====
// data ram model: 64 nibbles, combinational read
// assumes the bench preloads words through mem
`timescale 1ns/1ps
`default_nettype none
module nibble_ram_model (
	input wire logic [5:0] ram_addr, // bank and word pointer
	output logic [3:0] ram_rdata // addressed word
);
	logic [3:0] mem [64];
	initial foreach (mem[a]) mem[a] = 4'(a) ^ 4'h5;
	assign ram_rdata = mem[ram_addr];
endmodule
`default_nettype wire

// ==== tb/nibble_alu_call_stack_sva.sv ====
// assertions for the nibble execution unit
// bound to nibble_alu_call_stack, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_call_stack_chk
	import nibble_alu_pkg::*;
#(
	parameter int PC_W = 10
) (
	input wire logic core_clk, // clock
	input wire logic arst_n, // reset
	input wire exec_req_t req, // instr
	input wire logic [PC_W-1:0] call_target, // target
	input wire logic [PC_W-1:0] next_pc, // pc+1
	input wire logic [3:0] ram_rdata, // ram word
	input wire logic [5:0] ram_addr, // ram addr
	input wire logic pc_load, // pc strobe
	input wire logic [PC_W-1:0] pc_value, // new pc
	input wire logic long_call, // long call
	input wire logic [3:0] active_rom_bank, // bank
	input wire logic [3:0] rom_bank_buffer, // buffer
	input wire logic condition_flag, // flag
	input wire logic [3:0] acc, // acc
	input wire logic [2:0] reg_addr, // index
	input wire logic [3:0] reg_wdata, // wdata
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [3:0] reg_rdata // rdata
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	logic v;
	assign v = req.valid;
	AST_CALL_TAKEN:
	assert property (v && req.op == OP_CALL && condition_flag |=> pc_load && pc_value == $past(call_target)
		&& active_rom_bank == $past(rom_bank_buffer)) else $error("taken call wrong");
	AST_CALL_SKIP:
	assert property (v && req.op == OP_CALL && !condition_flag |=> pc_load && pc_value == $past(next_pc)
		&& condition_flag && $stable(active_rom_bank)) else $error("untaken call wrong");
	AST_LONG_CALL:
	assert property (v && req.op == OP_CALL && condition_flag
		|=> long_call == ($past(rom_bank_buffer) != $past(active_rom_bank))) else $error("long call wrong");
	AST_RETURN:
	assert property (v && req.op == OP_SUBROUTINE_RETURN |=> pc_load && condition_flag
		&& active_rom_bank == rom_bank_buffer) else $error("return wrong");
	AST_ADD:
	assert property (v && req.op == OP_ADD_MEMORY
		|=> {condition_flag, acc} == 5'($past(ram_rdata)) + 5'($past(acc))) else $error("add wrong");
	AST_SUB:
	assert property (v && req.op == OP_SUBTRACT_FROM_MEMORY |=> acc == 4'($past(ram_rdata) - $past(acc))
		&& condition_flag == ($past(acc) <= $past(ram_rdata))) else $error("subtract wrong");
	AST_INC_ACC:
	assert property (v && req.op == OP_INCREMENT_ACC |=> acc == 4'($past(acc) + 4'h1) && condition_flag)
		else $error("inc acc wrong");
	AST_WORD_INC:
	assert property (v && req.op == OP_INCREMENT_WORD_POINTER |=> ram_addr[3:0] == 4'($past(ram_addr[3:0]) + 4'h1)
		&& condition_flag == ($past(ram_addr[3:0]) == 4'hf)) else $error("inc word pointer wrong");
	AST_LE_IMM:
	assert property (v && req.op == OP_ACC_LE_IMMEDIATE
		|=> condition_flag == ($past(acc) <= $past(req.imm)) && $stable(acc)) else $error("le imm wrong");
endmodule
bind nibble_alu_call_stack nibble_alu_call_stack_chk #(.PC_W(PC_W)) i_chk (.core_clk(core_clk), .arst_n(arst_n),
	.req(req), .call_target(call_target), .next_pc(next_pc), .ram_rdata(ram_rdata), .ram_addr(ram_addr),
	.pc_load(pc_load), .pc_value(pc_value), .long_call(long_call), .active_rom_bank(active_rom_bank),
	.rom_bank_buffer(rom_bank_buffer), .condition_flag(condition_flag), .acc(acc), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// ==== tb/nibble_alu_call_stack_tb.sv ====
// bench for the nibble execution unit: register port, alu sweep, call stack
// assumes the ram model answers combinationally; bench plays the sequencer
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_call_stack_tb;
	import nibble_alu_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	exec_req_t req = '0;
	logic [9:0] call_target = '0;
	logic [9:0] next_pc = '0;
	logic [2:0] reg_addr = '0;
	logic [3:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] ram_rdata, active_rom_bank, rom_bank_buffer, acc, reg_rdata, ea, ew, eb;
	logic [5:0] ram_addr;
	logic [9:0] pc_value;
	logic pc_load, long_call, condition_flag, ef;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [3:0] vals [4] = '{4'h0, 4'h1, 4'h7, 4'hf};
	logic [3:0] rst_val [8] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
	always #5 core_clk = ~core_clk;
	nibble_alu_call_stack #(.PC_W(10)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .req(req),
		.call_target(call_target), .next_pc(next_pc), .ram_rdata(ram_rdata), .ram_addr(ram_addr),
		.pc_load(pc_load), .pc_value(pc_value), .long_call(long_call), .active_rom_bank(active_rom_bank),
		.rom_bank_buffer(rom_bank_buffer), .condition_flag(condition_flag), .acc(acc), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	nibble_ram_model i_mem (.ram_addr(ram_addr), .ram_rdata(ram_rdata));
	// ----------------------------------------------------------------
	// port tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input op_t o, input logic [3:0] i, input logic [9:0] t, input logic [9:0] n);
		@(posedge core_clk);
		req <= '{1'b1, o, i};
		call_target <= t;
		next_pc <= n;
		@(posedge core_clk);
		req <= '0;
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [3:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [3:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", 10'(e), 10'(reg_rdata));
	endtask
	// expected acc, word pointer and flag; acc doubles as word pointer value
	task automatic refm(input op_t o, input logic [3:0] a, input logic [3:0] m);
		logic [4:0] s;
		s = 5'(a) + 5'(m);
		ea = a;
		ew = a;
		ef = 1'b1;
		case (o)
			OP_NOP: ef = 1'b1;
			OP_LOAD_BANK_BUFFER_IMM: eb = m;
			OP_ADD_MEMORY: {ef, ea} = s;
			OP_SUBTRACT_FROM_MEMORY: begin ea = m - a; ef = a <= m; end
			OP_INCREMENT_MEMORY: begin ea = m + 4'h1; ef = m == 4'hf; end
			OP_DECREMENT_MEMORY: begin ea = m + 4'hf; ef = m != 4'h0; end
			OP_INCREMENT_ACC: ea = a + 4'h1;
			OP_INCREMENT_WORD_POINTER: begin ew = a + 4'h1; ef = a == 4'hf; end
			OP_DECREMENT_ACC: begin ea = a + 4'hf; ef = a != 4'h0; end
			OP_DECREMENT_WORD_POINTER: begin ew = a + 4'hf; ef = a != 4'h0; end
			OP_XOR_MEMORY: ea = a ^ m;
			OP_TWOS_COMPLEMENT_ACC: begin ea = ~a + 4'h1; ef = a == 4'h0; end
			OP_ACC_LE_MEMORY, OP_ACC_LE_IMMEDIATE: ef = a <= m;
			OP_MEMORY_NONZERO_TEST: ef = m != 4'h0;
			default: ef = 1'b0;
		endcase
	endtask
	task automatic do_call(input logic [3:0] b, input logic [9:0] t, input logic [9:0] n, input logic lg);
		run(OP_LOAD_BANK_BUFFER_IMM, b, '0, '0);
		run(OP_CALL, 4'h0, t, n);
		chk("call pc", t, pc_value);
		chk("call load long bank", 10'({1'b1, lg, b}), 10'({pc_load, long_call, active_rom_bank}));
	endtask
	task automatic do_ret(input logic [9:0] p, input logic [3:0] b);
		run(OP_SUBROUTINE_RETURN, 4'h0, '0, '0);
		chk("ret pc", p, pc_value);
		chk("ret flag", 10'(1'b1), 10'(condition_flag));
		chk("ret banks", 10'({b, b}), 10'({active_rom_bank, rom_bank_buffer}));
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// whole run is about two thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		eb = 4'h0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int r = 0; r < 8; r++) rd(3'(r), rst_val[r]);
		wr(REG_BANK_PTR, 4'h2);
		foreach (vals[x]) foreach (vals[y]) for (int k = 0; k < 18; k++) begin
			if (k == 1 || k == 2) continue;
			wr(REG_ACC, vals[x]);
			wr(REG_WORD_PTR, vals[x]);
			wr(REG_FLAG, 4'h0);
			i_mem.mem[{2'h2, vals[x]}] = vals[y];
			refm(op_t'(k), vals[x], vals[y]);
			run(op_t'(k), vals[y], '0, '0);
			chk("acc", 10'(ea), 10'(acc));
			chk("load flag", 10'({1'b0, ef}), 10'({pc_load, condition_flag}));
			chk("ram addr", 10'({2'h2, ew}), 10'(ram_addr));
			chk("buffer", 10'(eb), 10'(rom_bank_buffer));
		end
		do_call(4'h3, 10'h100, 10'h011, 1'b1);
		do_call(4'h3, 10'h120, 10'h101, 1'b0);
		do_call(4'h5, 10'h200, 10'h121, 1'b1);
		do_call(4'h6, 10'h300, 10'h201, 1'b1);
		rd(REG_STACK_LEVEL, 4'h3);
		do_ret(10'h201, 4'h5);
		do_ret(10'h121, 4'h3);
		do_ret(10'h101, 4'h3);
		do_ret(10'h101, 4'h3);
		wr(REG_FLAG, 4'h0);
		run(OP_CALL, 4'h0, 10'h3ff, 10'h102);
		chk("skip pc", 10'h102, pc_value);
		chk("skip load flag bank", 10'({1'b1, 1'b1, 4'h3}), 10'({pc_load, condition_flag, active_rom_bank}));
		rd(REG_STACK_LEVEL, 4'h0);
		wr(REG_ACTIVE_BANK, 4'h9);
		rd(REG_ACTIVE_BANK, 4'h3);
		wrap_up();
	end
endmodule
`default_nettype wire
